// ==== hdl/tim_pkg.sv ====
/*
  constants, field positions and codes shared by the capture/compare/pwm block.
  assumes an 8-bit register port with a 4-bit register index.
*/
package tim_pkg;
  // ****************************************
  // register indices
  // ****************************************
  localparam logic [3:0] OFS_STATUS   = 4'h0;
  localparam logic [3:0] OFS_CNT_HI   = 4'h1;
  localparam logic [3:0] OFS_CNT_LO   = 4'h2;
  localparam logic [3:0] OFS_MOD_HI   = 4'h3;
  localparam logic [3:0] OFS_MOD_LO   = 4'h4;
  localparam logic [3:0] OFS_CH0_CTRL = 4'h5;
  localparam logic [3:0] OFS_CH0_HI   = 4'h6;
  localparam logic [3:0] OFS_CH0_LO   = 4'h7;
  localparam logic [3:0] OFS_CH1_CTRL = 4'h8;
  localparam logic [3:0] OFS_CH1_HI   = 4'h9;
  localparam logic [3:0] OFS_CH1_LO   = 4'hA;

  // ****************************************
  // field positions
  // ****************************************
  localparam int BIT_FLAG   = 7;
  localparam int BIT_IE     = 6;
  localparam int BIT_LINK   = 5;
  localparam int BIT_STOP   = 5;
  localparam int BIT_TRST   = 4;
  localparam int BIT_MODE   = 4;
  localparam int BIT_ELS_HI = 3;
  localparam int BIT_ELS_LO = 2;
  localparam int BIT_TOV    = 1;
  localparam int BIT_MAX    = 0;

  // ****************************************
  // reset values, masks and synchroniser latency
  // ****************************************
  localparam logic [15:0] MOD_RESET    = 16'hFFFF;
  localparam logic [6:0]  CTRL_RESET   = 7'h00;
  localparam logic        STOP_RESET   = 1'h1;
  localparam logic [7:0]  CH0_WR_MASK  = 8'h7F;
  localparam logic [7:0]  CH1_WR_MASK  = 8'h5F;
  localparam int          SYNC_LATENCY = 2;

  // ****************************************
  // codes
  // ****************************************
  typedef enum logic [1:0] {
    EDGE_NONE = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_ANY  = 2'h3
  } edge_sel_e;

  typedef enum logic [1:0] {
    ACT_OFF    = 2'h0,
    ACT_TOGGLE = 2'h1,
    ACT_CLEAR  = 2'h2,
    ACT_SET    = 2'h3
  } cmp_act_e;
endpackage

// ==== hdl/tick_counter.sv ====
/*
  shared 16-bit up-counter with modulo wrap.
  assumes reset already synchronised to mclk.
*/
`timescale 1ns/1ps
module tick_counter
  import tim_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        stop,
  input  wire logic        clear,
  input  wire logic [15:0] modulo,
  output logic      [15:0] count,
  output logic      [15:0] next_count,
  output logic             step,
  output logic             wrap
);
  // ****************************************
  // counting
  // ****************************************
  assign step       = !stop;
  assign wrap       = step && (count == modulo);
  assign next_count = wrap ? 16'h0000 : 16'(count + 16'h0001);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      count <= 16'h0000;
    else if (clear)
      count <= 16'h0000;
    else if (step)
      count <= next_count;
  end
endmodule // tick_counter

// ==== hdl/edge_capture.sv ====
/*
  pin synchroniser and selectable edge detector for one capture input.
  assumes the pin is asynchronous to mclk.
*/
`timescale 1ns/1ps
module edge_capture
  import tim_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       pin,
  input  wire logic [1:0] edge_sel,
  output logic            hit
);
  logic sync1;
  logic sync2;
  logic prev;

  // ****************************************
  // two-stage synchroniser
  // ****************************************
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= 1'h0;
      sync2 <= 1'h0;
      prev  <= 1'h0;
    end
    else
    begin
      sync1 <= pin;
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  // ****************************************
  // edge select
  // ****************************************
  always_comb
  begin
    unique case (edge_sel)
      EDGE_RISE: hit = sync2 && !prev;
      EDGE_FALL: hit = !sync2 && prev;
      EDGE_ANY:  hit = sync2 ^ prev;
      EDGE_NONE: hit = 1'h0;
    endcase
  end

  a_edge_once: assert property (@(posedge mclk) disable iff (!rst_n)
    hit |=> !hit)
    else $error("edge hit lasted more than one cycle");
endmodule // edge_capture

// ==== hdl/two_channel_capture_compare_pwm.sv ====
/*
  two-channel capture / compare / pwm block with its registers.
  assumes a single-cycle register port on mclk and asynchronous channel pins.
*/
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module two_channel_capture_compare_pwm
  import tim_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wstrobe,
  input  wire logic       rstrobe,
  output logic      [7:0] rdata,
  input  wire logic       chan0_pin_in,
  output logic            chan0_pin_out,
  output logic            chan0_pin_oe,
  input  wire logic       chan1_pin_in,
  output logic            chan1_pin_out,
  output logic            chan1_pin_oe,
  output logic      [1:0] chan_irq,
  output logic            overflow_irq
);
  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta <= 1'h0;
      rst_n    <= 1'h0;
    end
    else
    begin
      rst_meta <= 1'h1;
      rst_n    <= rst_meta;
    end
  end

  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ****************************************
  // timer status and counter
  // ****************************************
  logic        overflow_flag;
  logic        overflow_irq_enable;
  logic        stop;
  logic [15:0] modulo;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic        step;
  logic        wrap;
  logic        wr_status;
  logic        clr_cnt;

  assign wr_status = wstrobe && (addr == OFS_STATUS);
  assign clr_cnt   = wr_status && wdata[BIT_TRST];

  tick_counter u_counter (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .stop       (stop),
    .clear      (clr_cnt),
    .modulo     (modulo),
    .count      (cnt),
    .next_count (next_cnt),
    .step       (step),
    .wrap       (wrap)
  );

  // set wins over a software clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      overflow_flag <= 1'h0;
    else if (wrap)
      overflow_flag <= 1'h1;
    else if (wr_status && !wdata[BIT_FLAG])
      overflow_flag <= 1'h0;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      overflow_irq_enable <= 1'h0;
      stop                <= STOP_RESET;
    end
    else if (wr_status)
    begin
      overflow_irq_enable <= wdata[BIT_IE];
      stop                <= wdata[BIT_STOP];
    end
  end

  // period is modulo plus one counts
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      modulo <= MOD_RESET;
    else if (wstrobe && addr == OFS_MOD_HI)
      modulo[15:8] <= wdata;
    else if (wstrobe && addr == OFS_MOD_LO)
      modulo[7:0] <= wdata;
  end

  assign overflow_irq = overflow_flag && overflow_irq_enable;

  // ****************************************
  // buffered pair selection
  // ****************************************
  logic       link;
  logic       sel;
  logic       last1;
  logic       next_last;
  logic       wr_val0;
  logic       wr_val1;
  logic [7:0] ctrl [2];
  logic [15:0] val [2];

  assign link    = ctrl[0][BIT_LINK];
  assign wr_val0 = wstrobe && (addr == OFS_CH0_HI || addr == OFS_CH0_LO);
  assign wr_val1 = wstrobe && (addr == OFS_CH1_HI || addr == OFS_CH1_LO);

  always_comb
  begin
    next_last = last1;
    if (wr_val1)
      next_last = 1'h1;
    else if (wr_val0)
      next_last = 1'h0;
  end

  // channel 0 always starts in control after linking
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel   <= 1'h0;
      last1 <= 1'h0;
    end
    else if (!link)
    begin
      sel   <= 1'h0;
      last1 <= 1'h0;
    end
    else
    begin
      last1 <= next_last;
      if (wrap)
        sel <= next_last;
    end
  end

  // ****************************************
  // channels
  // ****************************************
  logic [1:0] pin_in;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic [1:0] flag;
  logic [1:0] edge_hit;
  logic [1:0] cap;
  logic [1:0] match;
  logic [1:0] cmp_mode;
  logic [1:0] active;

  assign pin_in = {chan1_pin_in, chan0_pin_in};

  for (genvar i = 0; i < 2; i++)
  begin : g_chan
    localparam logic [3:0] CTRL_OFS = (i == 0) ? OFS_CH0_CTRL : OFS_CH1_CTRL;
    localparam logic [3:0] HI_OFS   = (i == 0) ? OFS_CH0_HI : OFS_CH1_HI;
    localparam logic [3:0] LO_OFS   = (i == 0) ? OFS_CH0_LO : OFS_CH1_LO;
    localparam logic [7:0] WR_MASK  = (i == 0) ? CH0_WR_MASK : CH1_WR_MASK;
    logic        wr_ctrl;
    logic [15:0] cmp_val;
    logic        tov;
    logic        max_duty;
    logic [1:0]  els;
    logic        next_pin;
    logic [6:0]  ctrl_bits;

    assign wr_ctrl  = wstrobe && (addr == CTRL_OFS);
    assign tov      = ctrl[i][BIT_TOV];
    assign max_duty = ctrl[i][BIT_MAX];
    assign els      = ctrl[i][BIT_ELS_HI:BIT_ELS_LO];

    // while linked, channel 1 is idle and its control bits other than BIT_IE and the BIT_FLAG clear are ignored
    assign active[i]   = (i == 0) || !link;
    assign cmp_mode[i] = ((i == 0) && link) || ctrl[i][BIT_MODE];

    edge_capture u_edge (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .pin      (pin_in[i]),
      .edge_sel (els),
      .hit      (edge_hit[i])
    );

    assign cap[i] = active[i] && !cmp_mode[i] && edge_hit[i];

    // unbuffered compare reads the live value register
    assign cmp_val = ((i == 0) && link && sel) ? val[1] : val[i];

    // next_cnt is the count this edge lands on, so one action per step
    assign match[i] = active[i] && cmp_mode[i] && step
                      && (next_cnt == cmp_val);

    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
        ctrl_bits <= CTRL_RESET;
      else if (wr_ctrl)
        ctrl_bits <= wdata[6:0] & WR_MASK[6:0];
    end
    assign ctrl[i] = {flag[i], ctrl_bits};

    // set wins over a software clear in the same cycle
    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
        flag[i] <= 1'h0;
      else if (cap[i] || match[i])
        flag[i] <= 1'h1;
      else if (wr_ctrl && !wdata[BIT_FLAG])
        flag[i] <= 1'h0;
    end

    // no reset: contents survive system reset
    always_ff @(posedge mclk)
    begin
      if (cap[i])
        val[i] <= cnt;
      else if (wstrobe && addr == HI_OFS)
        val[i][15:8] <= wdata;
      else if (wstrobe && addr == LO_OFS)
        val[i][7:0] <= wdata;
    end

    // overflow toggle first, then the compare action on top of it
    always_comb
    begin
      next_pin = pin_out[i];
      if (tov && max_duty)
        next_pin = 1'h1;
      else
      begin
        if (wrap && tov)
          next_pin = !next_pin;
        if (match[i])
        begin
          unique case (cmp_act_e'(els))
            ACT_TOGGLE: next_pin = !next_pin;
            ACT_CLEAR:  next_pin = 1'h0;
            ACT_SET:    next_pin = 1'h1;
            ACT_OFF:    next_pin = next_pin;
          endcase
        end
      end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
      if (!rst_n)
        pin_out[i] <= 1'h0;
      else if (active[i] && cmp_mode[i])
        pin_out[i] <= next_pin;
    end

    assign pin_oe[i]   = active[i] && cmp_mode[i] && (els != EDGE_NONE);
    assign chan_irq[i] = flag[i] && ctrl[i][BIT_IE];
  end

  assign chan0_pin_out = pin_out[0];
  assign chan0_pin_oe  = pin_oe[0];
  assign chan1_pin_out = pin_out[1];
  assign chan1_pin_oe  = pin_oe[1];

  // ****************************************
  // register read
  // ****************************************
  logic [7:0] rd_mux;

  always_comb
  begin
    unique case (addr)
      OFS_STATUS:   rd_mux = {overflow_flag, overflow_irq_enable, stop, 5'h00};
      OFS_CNT_HI:   rd_mux = cnt[15:8];
      OFS_CNT_LO:   rd_mux = cnt[7:0];
      OFS_MOD_HI:   rd_mux = modulo[15:8];
      OFS_MOD_LO:   rd_mux = modulo[7:0];
      OFS_CH0_CTRL: rd_mux = ctrl[0];
      OFS_CH0_HI:   rd_mux = val[0][15:8];
      OFS_CH0_LO:   rd_mux = val[0][7:0];
      OFS_CH1_CTRL: rd_mux = ctrl[1];
      OFS_CH1_HI:   rd_mux = val[1][15:8];
      OFS_CH1_LO:   rd_mux = val[1][7:0];
      default:      rd_mux = 8'h00;
    endcase
  end

  // data stand only in the cycle after the read strobe
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else if (rstrobe)
      rdata <= rd_mux;
    else
      rdata <= 8'h00;
  end

  // ****************************************
  // checks
  // ****************************************
  a_capture_value: assert property (cap[0] |=> val[0] == $past(cnt))
    else $error("capture did not latch the count");

  a_capture_flag: assert property (cap[0] |=> flag[0])
    else $error("capture did not set the channel flag");

  logic els_rise0;
  assign els_rise0 = (ctrl[0][BIT_ELS_HI:BIT_ELS_LO] == EDGE_RISE);

  a_capture_delay: assert property (
    cap[0] && els_rise0 |-> $past(pin_in[0], 2) && !$past(pin_in[0], 3))
    else $error("capture not two cycles after the pin edge");

  a_overflow_flag: assert property (wrap |=> overflow_flag && cnt == 16'h0000)
    else $error("wrap did not set the overflow flag");

  a_link_release: assert property (link |-> !chan1_pin_oe && !match[1])
    else $error("channel 1 still active while linked");

  a_max_duty: assert property (
    cmp_mode[0] && ctrl[0][BIT_TOV] && ctrl[0][BIT_MAX] |=> chan0_pin_out)
    else $error("max duty did not hold the pin high");

  a_overflow_toggle: assert property (
    wrap && cmp_mode[0] && ctrl[0][BIT_TOV] && !ctrl[0][BIT_MAX] && !match[0]
    |=> chan0_pin_out != $past(chan0_pin_out))
    else $error("pin did not toggle on overflow");

  a_buffer_swap: assert property (link && wrap |=> sel == $past(next_last))
    else $error("buffered pair did not switch at overflow");

  a_single_match: assert property (match[0] && modulo != 16'h0000 |=> !match[0])
    else $error("compare matched on two successive steps");
endmodule // two_channel_capture_compare_pwm

// ==== test/pin_partner.sv ====
/*
  far side of the two channel pins: a source that drives each pin wire
  whenever the block leaves it undriven.
  assumes the bench sets drive_lvl just after a rising mclk edge.
*/
`timescale 1ns/1ps
module pin_partner
(
  input  wire logic [1:0] drive_lvl,
  input  wire logic [1:0] pin_out,
  input  wire logic [1:0] pin_oe,
  output logic      [1:0] pin_lvl
);
  // ****************************************
  // wire resolution
  // ****************************************
  // a released pin carries the source level, so a pin handed back to gpio
  // never shows the block's stale drive value
  assign pin_lvl[0] = pin_oe[0] ? pin_out[0] : drive_lvl[0];
  assign pin_lvl[1] = pin_oe[1] ? pin_out[1] : drive_lvl[1];
endmodule // pin_partner

// ==== test/two_channel_capture_compare_pwm_tb_top.sv ====
/*
  self-checking bench: register port tasks, capture, compare, pwm, link.
  assumes the design files and pin_partner are compiled first.
*/
`timescale 1ns/1ps
module two_channel_capture_compare_pwm_tb_top
  import tim_pkg::*;
;
  logic       mclk;
  logic       resetn;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic       wstrobe;
  logic       rstrobe;
  logic [7:0] rdata;
  logic [1:0] ext_lvl;
  logic [1:0] pin_lvl;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  logic [1:0] chan_irq;
  logic       overflow_irq;
  int         err_count;
  int         checked;
  logic [7:0] last;
  logic [7:0] v0;

  two_channel_capture_compare_pwm u_dut (
    .mclk(mclk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wstrobe(wstrobe), .rstrobe(rstrobe), .rdata(rdata),
    .chan0_pin_in(pin_lvl[0]), .chan0_pin_out(pin_out[0]), .chan0_pin_oe(pin_oe[0]),
    .chan1_pin_in(pin_lvl[1]), .chan1_pin_out(pin_out[1]), .chan1_pin_oe(pin_oe[1]),
    .chan_irq(chan_irq), .overflow_irq(overflow_irq)
  );

  pin_partner u_pins (
    .drive_lvl(ext_lvl), .pin_out(pin_out), .pin_oe(pin_oe), .pin_lvl(pin_lvl)
  );

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr    <= a;
    wdata   <= d;
    wstrobe <= 1'b1;
    @(posedge mclk);
    wstrobe <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr    <= a;
    rstrobe <= 1'b1;
    @(posedge mclk);
    rstrobe <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(d, e);
  endtask

  // pin moves one edge after the count is sampled; capture reads that count + 4
  task automatic pulse(input logic lvl, input logic hit, input logic pre);
    logic [7:0] c;
    logic [7:0] e;
    logic [7:0] v;
    rd(OFS_CNT_LO, c);
    e = c + 8'h04;
    @(posedge mclk);
    ext_lvl[0] <= lvl;
    repeat (2) @(posedge mclk);
    #1;
    chk(chan_irq[0], pre);
    @(posedge mclk);
    #1;
    chk(chan_irq[0], pre | hit);
    rd(OFS_CH0_LO, v);
    chk(v, hit ? e : last);
    if (hit)
      last = e;
  endtask

  // settle first: an unsynchronised value change may misbehave two periods
  task automatic duty(input int n, input int e);
    int h;
    h = 0;
    repeat (600) @(posedge mclk);
    repeat (n)
    begin
      @(posedge mclk);
      #1;
      if (pin_lvl[0] === 1'b1)
        h++;
    end
    chk(h[15:0], e[15:0]);
  endtask

  task automatic wait_hi(input logic sel);
    int i;
    for (i = 0; i < 300; i++)
    begin
      @(posedge mclk);
      #1;
      if ((sel ? chan_irq[0] : overflow_irq) === 1'b1)
        break;
    end
    chk(sel ? chan_irq[0] : overflow_irq, 1'b1);
  endtask

  task automatic end_of_test;
    $display("errors %0d checks %0d", err_count, checked);
    if (err_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ****************************************
  // clock, watchdog
  // ****************************************
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  initial
  begin
    repeat (100000) @(posedge mclk);
    err_count++;
    end_of_test;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    resetn = 1'b0; addr = 4'h0; wdata = 8'h00; wstrobe = 1'b0; rstrobe = 1'b0;
    ext_lvl = 2'h0; err_count = 0; checked = 0; last = 8'h00;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    rdc(OFS_STATUS, 8'h20);
    rdc(OFS_MOD_HI, 8'hFF);
    rdc(OFS_MOD_LO, 8'hFF);
    rdc(OFS_CH0_CTRL, 8'h00);
    wr(4'hB, 8'hFF);
    rdc(4'hB, 8'h00);
    // value registers have no reset; give them a known start
    wr(OFS_CH0_HI, 8'h00);
    wr(OFS_CH0_LO, 8'h00);
    wr(OFS_STATUS, 8'h10);
    for (int s = 0; s < 4; s++)
    begin
      wr(OFS_CH0_CTRL, {4'h4, s[1:0], 2'h0});
      pulse(1'b1, s == 1 || s == 3, 1'b0);
      wr(OFS_CH0_CTRL, {4'h4, s[1:0], 2'h0});
      pulse(1'b0, s >= 2, 1'b0);
    end
    pulse(1'b1, 1'b1, 1'b1);
    wr(OFS_CH1_CTRL, 8'h44);
    ext_lvl[1] <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    chk(chan_irq[1], 1'b1);
    rdc(OFS_CH0_HI, 8'h00);
    rd(OFS_CH0_LO, v0);
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    repeat (3) @(posedge mclk);
    rdc(OFS_CH0_LO, v0);
    wr(OFS_MOD_HI, 8'h00);
    wr(OFS_MOD_LO, 8'hFF);
    wr(OFS_CH0_HI, 8'h00);
    wr(OFS_CH0_LO, 8'h80);
    wr(OFS_CH0_CTRL, 8'h1A);
    wr(OFS_STATUS, 8'h00);
    duty(512, 256);
    wr(OFS_CH0_LO, 8'h20);
    duty(512, 64);
    wr(OFS_CH0_LO, 8'hC0);
    duty(512, 384);
    wr(OFS_CH0_LO, 8'h80);
    wr(OFS_MOD_LO, 8'hFE);
    // restart the count: it may already sit above the new modulo
    wr(OFS_STATUS, 8'h10);
    duty(510, 256);
    wr(OFS_MOD_LO, 8'hFF);
    wr(OFS_CH0_CTRL, 8'h1B);
    duty(300, 300);
    wr(OFS_CH0_CTRL, 8'h18);
    duty(300, 0);
    wr(OFS_CH0_CTRL, 8'h1C);
    duty(300, 300);
    wr(OFS_CH0_CTRL, 8'h10);
    #1;
    chk(pin_oe[0], 1'b0);
    wr(OFS_STATUS, 8'h40);
    wait_hi(1'b0);
    wr(OFS_CH0_CTRL, 8'h58);
    wait_hi(1'b1);
    wr(OFS_CH0_LO, 8'h40);
    wr(OFS_CH1_CTRL, 8'h1C);
    wr(OFS_CH0_CTRL, 8'h2A);
    ext_lvl[1] <= 1'b1;
    duty(512, 128);
    chk(pin_oe[1], 1'b0);
    chk(pin_lvl[1], 1'b1);
    wr(OFS_CH1_HI, 8'h00);
    wr(OFS_CH1_LO, 8'hC0);
    duty(512, 384);
    wr(OFS_CH0_LO, 8'h20);
    duty(512, 64);
    end_of_test;
  end
endmodule // two_channel_capture_compare_pwm_tb_top
